// [hw/chan_sel_pkg.sv]
package chan_sel_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] OFF_CH123 = 4'h0;
  localparam logic [3:0] OFF_CH0 = 4'h4;
  localparam logic [3:0] OFF_SCANH = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hC;

  // writable bit masks; zeros read back as zero, except CTRL bit 2, which reads use_set_b_q
  localparam logic [15:0] MASK_CH123 = 16'h1F1F;
  localparam logic [15:0] MASK_CH0 = 16'hBFBF;
  localparam logic [15:0] MASK_SCANH = 16'hFF0F;
  localparam logic [15:0] MASK_CTRL = 16'h0003;

  // reset values
  localparam logic [15:0] RST_CH123 = 16'h0000;
  localparam logic [15:0] RST_CH0 = 16'h0000;
  localparam logic [15:0] RST_SCANH = 16'h0000;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // field positions, channel 1-3 select
  localparam int SB_HI = 12;
  localparam int SB_LO0 = 8;
  localparam int SA_HI = 4;
  localparam int SA_LO0 = 0;
  localparam int NA_HI = 2;
  // field positions, channel 0 select
  localparam int C0_NB = 15;
  localparam int C0_PB_HI = 13;
  localparam int C0_NA = 7;
  localparam int C0_PA_HI = 5;
  // control register bits
  localparam int CTL_ALT = 0;
  localparam int CTL_SCAN = 1;

  // input index codes
  localparam logic [5:0] IN_VREFL = 6'h3F;
  localparam logic [6:0] SEL_VREFL = 7'h7F;
  localparam logic [2:0] NUM_AMPS = 3'h5;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [hw/scan_stepper.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// scan pointer: walks the enabled scan inputs
// ****************************************
module scan_stepper
  import chan_sel_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic [63:0] include_mask,
  input wire logic advance,
  // state
  output logic [5:0] index_q,
  output logic any_q
);

  logic [5:0] next_idx;
  logic found;

  // next set bit above the current index, wrapping round
  always_comb begin
    next_idx = index_q;
    found = 1'b0;
    for (int k = 1; k <= 64; k++) begin
      if (!found && include_mask[6'(index_q + 6'(k))]) begin
        next_idx = 6'(index_q + 6'(k));
        found = 1'b1;
      end
    end
  end

  // pointer moves only at the end of a sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= 6'h3F;
      any_q <= 1'b0;
    end else if (advance) begin
      index_q <= next_idx;
      any_q <= found;
    end
  end

endmodule

`default_nettype wire

// [hw/adc_input_channel_select.sv]
// Operation
// (R1) sample-B ch1-3 positive code is bits 12-11 over bit 8
// (R2) sample-A ch1-3 positive code is bits 4-3 over bit 0
// (R3) code 000 gives inputs 0,1,2; code 001 gives 3,4,5
// (R4) code 010 gives 3,0,6; code 011 gives 3,0,25
// (R5) top bit set gives 0,25,6 as amplifier outputs 2,5,3
// (R6) negative code 11 gives 9,10,11; 10 gives 6,7,8; 0x low reference
// (R7) ch0 sample-B negative bit 15 picks input 1 else low reference
// (R8) ch0 sample-A negative bit 7 picks input 1 else low reference
// (R9) ch0 sample-B positive bits 13-8 pick input by code; 61 band gap
// (R10) ch0 sample-A positive bits 5-0 pick input by code up to 63
// (R11) enabled amplifier output replaces its shared pin wherever selected
// (R12) inputs 0-7 are repurposed when amplifier functions are enabled
// (R13) scan-mask bits include inputs 31-24 and 19-16 when set
// (R14) mask bits 10,9,8 cover amplifier outputs 3,2,1 on inputs 6,0,3
// (R15) unimplemented register bits read as zero
// (R16) alternate mode uses set A then set B; else always set A
// (R17) scan enable steps ch0 positive through mask inputs in set A
// (R18) scan inputs with no physical pin convert the low reference
// (R19) selects clear at reset; writes apply to the next sample
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module adc_input_channel_select
  import chan_sel_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter side
  input wire logic sample_done,
  input wire logic [4:0] amplifier_enable,
  input wire logic [63:0] input_present,
  // mux selects: 0-63 analog input, 64+k amplifier output k+1, 127 low ref
  output logic [6:0] ch0_pos_sel_q,
  output logic [6:0] ch0_neg_sel_q,
  output logic [6:0] ch1_pos_sel_q,
  output logic [6:0] ch2_pos_sel_q,
  output logic [6:0] ch3_pos_sel_q,
  output logic [6:0] ch1_neg_sel_q,
  output logic [6:0] ch2_neg_sel_q,
  output logic [6:0] ch3_neg_sel_q,
  output logic use_set_b_q
);

  // ****************************************
  // register bus
  // ****************************************
  logic [15:0] ch123_q, ch0_q, scanh_q, ctrl_q;
  logic [3:0] awaddr_q;
  logic aw_held_q, w_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // address and data may arrive in either order; each is latched once
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_now = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire w_now = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = aw_now && w_now && !s_axi_bvalid;
  wire wr_hit = (wr_addr == OFF_CH123) || (wr_addr == OFF_CH0) ||
                (wr_addr == OFF_SCANH) || (wr_addr == OFF_CTRL);

  // byte-lane merge; unimplemented bits stay zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) v[7:0] = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    return v & m;
  endfunction

  wire wr_ch123 = wr_fire && (wr_addr == OFF_CH123);
  wire wr_ch0 = wr_fire && (wr_addr == OFF_CH0);
  wire wr_scanh = wr_fire && (wr_addr == OFF_SCANH);
  wire wr_ctrl = wr_fire && (wr_addr == OFF_CTRL);

  // write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awaddr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
        aw_held_q <= aw_now;
        w_held_q <= w_now;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // (R19) reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch123_q <= RST_CH123;
      ch0_q <= RST_CH0;
      scanh_q <= RST_SCANH;
      ctrl_q <= RST_CTRL;
    end else begin
      if (wr_ch123) ch123_q <= merge(ch123_q, wr_data, wr_strb, MASK_CH123);
      if (wr_ch0) ch0_q <= merge(ch0_q, wr_data, wr_strb, MASK_CH0);
      if (wr_scanh) scanh_q <= merge(scanh_q, wr_data, wr_strb, MASK_SCANH);
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wr_data, wr_strb, MASK_CTRL);
    end
  end

  // (R15) reserved bits zero
  logic [15:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_CH123: rd_val = ch123_q & MASK_CH123;
      OFF_CH0: rd_val = ch0_q & MASK_CH0;
      OFF_SCANH: rd_val = scanh_q & MASK_SCANH;
      OFF_CTRL: rd_val = {13'h0000, use_set_b_q, ctrl_q[1:0]};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // source substitution
  // ****************************************
  // (R11) amplifier replaces pin
  // pin of amplifier k+1; only units 1,2,3,5 have one
  function automatic logic [6:0] resolve(input logic [5:0] idx, input logic [4:0] en);
    logic [6:0] r;
    r = {1'b0, idx};
    // (R12) inputs 0-7 repurposed
    if (idx == 6'd3 && en[0]) r = 7'd64;
    if (idx == 6'd0 && en[1]) r = 7'd65;
    if (idx == 6'd6 && en[2]) r = 7'd66;
    if (idx == 6'd25 && en[4]) r = 7'd68;
    return r;
  endfunction

  // ch1-3 positive triple from a three-bit code
  function automatic logic [17:0] pos_triple(input logic [2:0] c);
    logic [17:0] t;
    case (c)
      // (R3) plain pin groups
      3'b000: t = {6'd0, 6'd1, 6'd2};
      3'b001: t = {6'd3, 6'd4, 6'd5};
      // (R4) amplifier mixes
      3'b010: t = {6'd3, 6'd0, 6'd6};
      3'b011: t = {6'd3, 6'd0, 6'd25};
      // (R5) top bit set
      default: t = {6'd0, 6'd25, 6'd6};
    endcase
    return t;
  endfunction

  // ****************************************
  // sample set and scan
  // ****************************************
  // (R1) set B code assembly
  wire [2:0] multi_ch_pos_sel_b = {ch123_q[SB_HI:SB_HI-1], ch123_q[SB_LO0]};
  // (R2) set A code assembly
  wire [2:0] multi_ch_pos_sel_a = {ch123_q[SA_HI:SA_HI-1], ch123_q[SA_LO0]};
  wire [1:0] multi_ch_neg_sel_a = ch123_q[NA_HI:NA_HI-1];
  wire first_ch_neg_sel_b = ch0_q[C0_NB];
  wire first_ch_neg_sel_a = ch0_q[C0_NA];
  wire [5:0] first_ch_pos_sel_b = ch0_q[C0_PB_HI:C0_PB_HI-5];
  wire [5:0] first_ch_pos_sel_a = ch0_q[C0_PA_HI:0];
  wire alternate_sample_sets = ctrl_q[CTL_ALT];
  wire scan_enable = ctrl_q[CTL_SCAN];

  // (R13) upper mask maps to inputs 31-24 and 19-16
  // (R14) bits 10,9,8 are inputs 26,25,24
  wire [63:0] scan_include_bit = {32'h0, scanh_q[15:8], 4'h0, scanh_q[3:0], 16'h0};
  logic [5:0] scan_idx_q;
  logic scan_any_q;

  // (R17) step only on set-A samples
  wire scan_adv = sample_done && scan_enable && !use_set_b_q;

  scan_stepper scan_stepper_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .include_mask(scan_include_bit),
    .advance(scan_adv),
    .index_q(scan_idx_q),
    .any_q(scan_any_q)
  );

  // (R16) alternate A then B
  always_ff @(posedge aclk) begin
    if (!aresetn) use_set_b_q <= 1'b0;
    else if (!alternate_sample_sets) use_set_b_q <= 1'b0;
    else if (sample_done) use_set_b_q <= !use_set_b_q;
  end

  // ****************************************
  // select decode
  // ****************************************
  wire [2:0] pos_code = use_set_b_q ? multi_ch_pos_sel_b : multi_ch_pos_sel_a;
  wire [17:0] trip = pos_triple(pos_code);
  wire scanning = scan_enable && !use_set_b_q;
  // (R14) scan slots 26,25,24 convert the shared pins 6,0,3
  wire [5:0] scan_src = (scan_idx_q == 6'd26) ? 6'd6 :
                        (scan_idx_q == 6'd25) ? 6'd0 :
                        (scan_idx_q == 6'd24) ? 6'd3 : scan_idx_q;
  wire [5:0] c0_code = scanning ? scan_src :
                       (use_set_b_q ? first_ch_pos_sel_b : first_ch_pos_sel_a);
  // (R18) absent scan input gives low reference
  wire c0_absent = scanning && (!scan_any_q || !input_present[scan_src]);
  // (R9) (R10) direct binary pick
  wire [6:0] c0_pos = c0_absent ? SEL_VREFL : resolve(c0_code, amplifier_enable);
  // (R7) (R8) input 1 or low reference
  wire c0_neg_bit = use_set_b_q ? first_ch_neg_sel_b : first_ch_neg_sel_a;
  wire [6:0] c0_neg = c0_neg_bit ? resolve(6'd1, amplifier_enable) : SEL_VREFL;

  // (R6) negative triple; set B uses the set-A code, its own field absent
  logic [6:0] n1, n2, n3;
  always_comb begin
    case (multi_ch_neg_sel_a)
      2'b11: begin
        n1 = 7'd9;
        n2 = 7'd10;
        n3 = 7'd11;
      end
      2'b10: begin
        n1 = resolve(6'd6, amplifier_enable);
        n2 = 7'd7;
        n3 = 7'd8;
      end
      default: begin
        n1 = SEL_VREFL;
        n2 = SEL_VREFL;
        n3 = SEL_VREFL;
      end
    endcase
  end

  // (R19) selects registered, so a write lands on the next sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch0_pos_sel_q <= 7'd0;
      ch0_neg_sel_q <= SEL_VREFL;
      ch1_pos_sel_q <= 7'd0;
      ch2_pos_sel_q <= 7'd1;
      ch3_pos_sel_q <= 7'd2;
      ch1_neg_sel_q <= SEL_VREFL;
      ch2_neg_sel_q <= SEL_VREFL;
      ch3_neg_sel_q <= SEL_VREFL;
    end else begin
      ch0_pos_sel_q <= c0_pos;
      ch0_neg_sel_q <= c0_neg;
      ch1_pos_sel_q <= resolve(trip[17:12], amplifier_enable);
      ch2_pos_sel_q <= resolve(trip[11:6], amplifier_enable);
      ch3_pos_sel_q <= resolve(trip[5:0], amplifier_enable);
      ch1_neg_sel_q <= n1;
      ch2_neg_sel_q <= n2;
      ch3_neg_sel_q <= n3;
    end
  end

endmodule

`default_nettype wire

// [verif/adc_input_channel_select_properties.sv]
`timescale 1ns/1ps
`default_nettype none

// ********
// port checker
// ********
module sel_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // converter side
  input wire logic sample_done,
  input wire logic use_set_b_q,
  input wire logic [6:0] ch0_neg_sel_q,
  input wire logic [6:0] ch1_pos_sel_q,
  input wire logic [6:0] ch1_neg_sel_q,
  input wire logic [6:0] ch2_neg_sel_q,
  input wire logic [6:0] ch3_neg_sel_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers arrive one cycle after the request is taken
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  AST_RD_UNIMPL: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // negative selects move as a group
  AST_NEG_REF: assert property (ch1_neg_sel_q == 7'h7F |->
    ch2_neg_sel_q == 7'h7F && ch3_neg_sel_q == 7'h7F) else $error("neg ref split");
  AST_NEG_HIGH: assert property (ch1_neg_sel_q == 7'h09 |->
    ch2_neg_sel_q == 7'h0A && ch3_neg_sel_q == 7'h0B) else $error("neg 9-11 split");
  AST_CH0_NEG: assert property (ch0_neg_sel_q == 7'h01 || ch0_neg_sel_q == 7'h7F)
    else $error("ch0 negative illegal");
  AST_CH1_POS: assert property (ch1_pos_sel_q inside {7'h00, 7'h03, 7'h40, 7'h41})
    else $error("ch1 positive illegal");
  // the set toggle only follows a finished sample
  AST_SET_HOLD: assert property (!sample_done && !$past(sample_done) |=>
    $stable(use_set_b_q)) else $error("set toggled without sample");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(use_set_b_q));
endmodule

bind adc_input_channel_select sel_checker sel_checker_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .sample_done(sample_done),
  .use_set_b_q(use_set_b_q),
  .ch0_neg_sel_q(ch0_neg_sel_q),
  .ch1_pos_sel_q(ch1_pos_sel_q),
  .ch1_neg_sel_q(ch1_neg_sel_q),
  .ch2_neg_sel_q(ch2_neg_sel_q),
  .ch3_neg_sel_q(ch3_neg_sel_q)
);

`default_nettype wire

// [verif/mux_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// ********
// converter and multiplexer stand-in
// ********
module mux_partner (
  // clock
  input wire logic aclk,
  // bench control
  input wire logic kick,
  input wire logic absent,
  // to the block
  output logic sample_done,
  output logic [63:0] input_present
);
  // one finished sample a cycle after each kick
  always_ff @(posedge aclk) begin
    sample_done <= kick;
  end
  // input 17 vanishes on request, to reach the missing-pin path
  assign input_present = ~(64'(absent) << 17);
endmodule

`default_nettype wire

// [verif/adc_input_channel_select_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_input_channel_select_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic kick = 1'b0;
  logic absent = 1'b0;
  logic [4:0] en = 5'h00;
  wire awready, wready, bvalid, arready, rvalid, sdone, setb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [63:0] present;
  wire [3:0][6:0] sp, sn;
  int bad_count = 0;
  int checks = 0;
  logic [15:0] rnd = 16'h0030;
  logic [15:0] ra, ca, m;
  logic [31:0] d;
  int pt[3][8] = '{'{0, 3, 3, 3, 0, 0, 0, 0}, '{1, 4, 0, 0, 25, 25, 25, 25},
    '{2, 5, 6, 25, 6, 6, 6, 6}};

  // 250 MHz
  always #2 aclk = ~aclk;

  adc_input_channel_select adc_input_channel_select_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_done(sdone), .amplifier_enable(en), .input_present(present),
    .ch0_pos_sel_q(sp[0]), .ch0_neg_sel_q(sn[0]), .ch1_pos_sel_q(sp[1]),
    .ch2_pos_sel_q(sp[2]), .ch3_pos_sel_q(sp[3]), .ch1_neg_sel_q(sn[1]),
    .ch2_neg_sel_q(sn[2]), .ch3_neg_sel_q(sn[3]), .use_set_b_q(setb));

  mux_partner mux_partner_inst (.aclk(aclk), .kick(kick), .absent(absent),
    .sample_done(sdone), .input_present(present));

  // ********
  // helpers
  // ********
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // shared pins swap to their amplifier when that amplifier is on
  function automatic logic [6:0] ai(input int i);
    case (i)
      3: return en[0] ? 7'h40 : 7'h03;
      0: return en[1] ? 7'h41 : 7'h00;
      6: return en[2] ? 7'h42 : 7'h06;
      25: return en[4] ? 7'h44 : 7'h19;
      default: return 7'(i);
    endcase
  endfunction

  task automatic stop_test();
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    chk(32'(n < 50), 32'h1);
    if (n >= 50) stop_test();
  endtask

  // bready comes a cycle late so the held response is exercised
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      // each channel lets go at the edge that takes it
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (((awv && !awready) || (wv && !wready)) && n < 50);
    @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 50);
    chk(32'(bresp), 32'h0);
    tmo(n);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 50);
    arv <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 50);
    v = rdata;
    chk(32'(rresp), (a[1:0] == 2'b00) ? 32'h0 : 32'h2);
    tmo(n);
  endtask

  task automatic pulse();
    kick <= 1'b1;
    @(posedge aclk);
    kick <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  // compare every select against the register image
  task automatic chk_all(input logic b);
    logic [2:0] pc;
    pc = b ? {ra[12:11], ra[8]} : {ra[4:3], ra[0]};
    chk(32'(sp[0]), 32'(ai(b ? ca[13:8] : ca[5:0])));
    chk(32'(sn[0]), (b ? ca[15] : ca[7]) ? 32'h1 : 32'h7F);
    for (int k = 1; k < 4; k++) begin
      chk(32'(sp[k]), 32'(ai(pt[k-1][pc])));
      chk(32'(sn[k]), ra[2] ? 32'(ai(ra[1] ? 8 + k : 5 + k)) : 32'h7F);
    end
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    ra = 16'h0000;
    ca = 16'h0000;
    for (int a = 0; a < 4; a++) begin
      rd(4'(4 * a), d);
      chk(d, 32'h0);
    end
    // unmapped slot answers with an error and zero data
    rd(4'h2, d);
    chk(d, 32'h0);
    chk_all(1'b0);
    // random fields, every set-A positive code among the first eight
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      ra = rnd;
      if (i < 8) ra[4:3] = i[2:1];
      if (i < 8) ra[0] = i[0];
      rnd = lfsr(rnd);
      ca = (i == 39) ? 16'hBDBF : rnd;
      rnd = lfsr(rnd);
      m = rnd;
      en <= rnd[4:0];
      wr(4'h0, ra);
      wr(4'h4, ca);
      wr(4'h8, m);
      rd(4'h0, d);
      chk(d, {16'h0, ra & 16'h1F1F});
      rd(4'h4, d);
      chk(d, {16'h0, ca & 16'hBFBF});
      rd(4'h8, d);
      chk(d, {16'h0, m & 16'hFF0F});
      chk_all(1'b0);
    end
    // alternate sets, every set-B positive code
    wr(4'hC, 16'h0001);
    rd(4'hC, d);
    chk(d, 32'h1);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ra = rnd;
      ra[12:11] = i[2:1];
      ra[8] = i[0];
      wr(4'h0, ra);
      pulse();
      chk(32'(setb), 32'h1);
      chk_all(1'b1);
      pulse();
      chk(32'(setb), 32'h0);
      chk_all(1'b0);
    end
    // scan through single mask bits, then a missing pin, then none
    wr(4'hC, 16'h0000);
    wr(4'h8, 16'h1000);
    wr(4'hC, 16'h0002);
    pulse();
    chk(32'(sp[0]), 32'd28);
    wr(4'h8, 16'h0002);
    pulse();
    chk(32'(sp[0]), 32'd17);
    absent <= 1'b1;
    pulse();
    chk(32'(sp[0]), 32'h7F);
    wr(4'h8, 16'h0000);
    pulse();
    chk(32'(sp[0]), 32'h7F);
    // mask bit 9 scans the pin shared with amplifier 2, here switched on
    en <= 5'h02;
    wr(4'h8, 16'h0200);
    pulse();
    chk(32'(sp[0]), 32'h41);
    stop_test();
  end
endmodule

`default_nettype wire
